/* File: common/sdram_host_pkg.sv */
package sdram_host_pkg;

    localparam int CLK_MHZ = 40;
    localparam int NUM_BANKS = 2;
    localparam int ADDR_W = 12;
    localparam int BANK_BIT = 11;
    localparam int AP_BIT = 10;
    localparam int COL_W = 8;
    localparam int ROW_W = 11;

    // timing figures, in ns; burst length in clock cycles
    localparam int T_RCD_NS = 20;
    localparam int T_RP_NS = 20;
    localparam int T_RAS_NS = 45;
    localparam int T_DAL_NS = 30;
    localparam int T_MCD_NS = 50;
    localparam int BURST_CYC = 1;

    localparam int RCD_RAW = (T_RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int RP_RAW = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int RAS_RAW = (T_RAS_NS * CLK_MHZ + 999) / 1000;
    localparam int DAL_RAW = (T_DAL_NS * CLK_MHZ + 999) / 1000;
    localparam int MCD_RAW = (T_MCD_NS * CLK_MHZ + 999) / 1000;
    localparam int RCD_CYC = (RCD_RAW < 1) ? 1 : RCD_RAW;
    localparam int RP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
    localparam int RAS_CYC = (RAS_RAW < 1) ? 1 : RAS_RAW;
    localparam int DAL_CYC = BURST_CYC + ((DAL_RAW < 1) ? 1 : DAL_RAW);
    localparam int MCD_CYC = (MCD_RAW < 1) ? 1 : MCD_RAW;
    localparam int RDAP_CYC = BURST_CYC + RP_CYC;

    // {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_DESELECT = 4'hF;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_STOP = 4'h6;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MODE = 4'h0;

    localparam logic [3:0] CMD_RST = CMD_DESELECT;
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam logic CKE_RST = 1'b1;

    typedef enum logic [3:0] {
        OP_ACT,
        OP_READ,
        OP_WRITE,
        OP_PRE,
        OP_PRECHARGE_ALL_CMD,
        OP_REF,
        OP_MODE,
        OP_STOP,
        OP_PDOWN,
        OP_SREF,
        OP_WAKE
    } host_op_t;

endpackage

/* File: src/sdram_bank_track.sv */
`timescale 1ns/100ps
module sdram_bank_track
    import sdram_host_pkg::*;
#(
    parameter int CW = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic act_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic auto_i,
    input wire logic pre_i,
    output logic idle_o,
    output logic open_o,
    output logic pre_ok_o
);

    typedef enum logic [2:0] {
        B_IDLE,
        B_OPENING,
        B_OPEN,
        B_WRAP,
        B_CLOSING
    } bank_state_t;

    localparam int RCD = RCD_CYC;
    localparam int DAL = DAL_CYC;
    localparam int RP = RP_CYC;
    localparam int RAS = RAS_CYC;
    localparam int DAL_M1 = DAL - 1;

    default clocking cb_bank @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    bank_state_t state_ff;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] ras_ff;
    logic [CW-1:0] age_ff;

    // per-bank state with delay counter loaded on entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin // see RL20
        if (!rst_n_i) begin
            state_ff <= B_IDLE;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                B_IDLE: begin
                    if (act_i) begin
                        state_ff <= B_OPENING; // see RL19
                        cnt_ff <= CW'(RCD_CYC);
                    end
                end
                B_OPENING, B_WRAP, B_CLOSING: begin
                    if (cnt_ff <= CW'(1)) begin
                        state_ff <= (state_ff == B_OPENING) ? B_OPEN : B_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - CW'(1);
                    end
                end
                B_OPEN: begin
                    if (wr_i && auto_i) begin
                        state_ff <= B_WRAP; // see RL3
                        cnt_ff <= CW'(DAL_CYC);
                    end else if (rd_i && auto_i) begin
                        state_ff <= B_CLOSING; // see RL16
                        cnt_ff <= CW'(RDAP_CYC);
                    end else if (pre_i) begin
                        state_ff <= B_CLOSING;
                        cnt_ff <= CW'(RP_CYC);
                    end
                end
                default: begin
                    state_ff <= B_IDLE;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    // row-active time since activate
    always_ff @(posedge clk_i or negedge rst_n_i) begin // see RL17
        if (!rst_n_i) begin
            ras_ff <= '0;
        end else if (act_i) begin
            ras_ff <= CW'(RAS_CYC);
        end else if (ras_ff != '0) begin
            ras_ff <= ras_ff - CW'(1);
        end
    end

    // assertion helper: cycles since last activate
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            age_ff <= '1;
        end else if (act_i) begin
            age_ff <= '0;
        end else if (age_ff != '1) begin
            age_ff <= age_ff + CW'(1);
        end
    end

    assign idle_o = (state_ff == B_IDLE);
    assign open_o = (state_ff == B_OPEN);
    assign pre_ok_o = open_o && (ras_ff == '0);

    sequence s_opening;
        !open_o && !idle_o;
    endsequence
    sequence s_act_open;
        s_opening ##RCD open_o;
    endsequence
    sequence s_wrap_done;
        s_opening ##DAL_M1 s_opening ##1 idle_o;
    endsequence
    sequence s_close_done;
        s_opening ##RP idle_o;
    endsequence

    a_act_to_open: assert property (act_i |=> s_act_open) // see RL19
        else $error("row not active exactly after activate delay");
    a_wrap_to_idle: assert property ( // see RL3
        (open_o && wr_i && auto_i) |=> s_wrap_done)
        else $error("auto-precharge write recovery length wrong");
    a_pre_to_idle: assert property ( // see RL20
        (open_o && pre_i && !rd_i && !wr_i) |=> s_close_done)
        else $error("precharge did not end after precharge time");
    a_ras_guard: assert property ( // see RL17
        pre_ok_o |-> (age_ff >= CW'(RAS)))
        else $error("precharge allowed before row-active time");

endmodule

/* File: src/sdram_host_ctrl.sv */
`timescale 1ns/100ps
// Overview of operation
// RL1: drive all pins from flops on rising edge
// RL2: encode commands on cs ras cas we
// RL3: auto-precharge write recovery returns bank idle
// RL4: no commands to bank in write recovery
// RL5: after refresh only quiet commands, wait precharge
// RL6: after mode set only quiet commands, wait
// RL7: refresh and mode set need both banks idle
// RL8: mode set drives full address as opcode
// RL9: refresh drives no meaningful address
// RL10: self refresh: only clock enable matters
// RL11: activate only an idle bank
// RL12: read or write only an active bank
// RL13: burst stop only when full page
// RL14: clock enable low, banks idle: power down
// RL15: clock enable low with refresh: self refresh
// RL16: auto-precharge burst closes bank itself
// RL17: precharge only after row-active time
// RL18: column commands: address bits 8,9 unused
// RL19: read or write waits for activate delay
// RL20: per-bank counters track every bank delay; refresh, mode set and wake waits use gcnt_ff
module sdram_host_ctrl
    import sdram_host_pkg::*;
#(
    parameter int NB = NUM_BANKS,
    parameter int CW = 8
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic REQ_VALID_I,
    input wire host_op_t REQ_OP_I,
    input wire logic REQ_BANK_I,
    input wire logic [ADDR_W-1:0] REQ_ADDR_I,
    input wire logic REQ_AUTO_PRE_I,
    input wire logic FULL_PAGE_I,
    output logic REQ_READY_O,
    output logic [NB-1:0] BANK_IDLE_O,
    output logic [NB-1:0] BANK_OPEN_O,
    output logic SD_CKE_O,
    output logic SD_CS_N_O,
    output logic SD_RAS_N_O,
    output logic SD_CAS_N_O,
    output logic SD_WE_N_O,
    output logic [ADDR_W-1:0] SD_ADDR_O
);

    typedef enum logic [2:0] {
        G_RUN,
        G_BUSY,
        G_PDOWN,
        G_SREF,
        G_WAKE
    } glob_state_t;

    localparam int RP = RP_CYC;
    localparam int MCD = MCD_CYC;

    default clocking cb_host @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    glob_state_t g_ff;
    logic [CW-1:0] gcnt_ff;
    logic [3:0] cmd_ff;
    logic [3:0] nxt_cmd;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic cke_ff;
    logic nxt_cke;
    logic [NB-1:0] idle_vec;
    logic [NB-1:0] open_vec;
    logic [NB-1:0] pre_ok_vec;
    logic [NB-1:0] prev_idle_ff;
    logic [NB-1:0] prev_open_ff;
    logic accept;
    logic run;
    logic all_idle;
    logic all_closable;

    assign run = (g_ff == G_RUN); // see RL10
    assign all_idle = &idle_vec;
    assign all_closable = &(idle_vec | pre_ok_vec);

    always_comb begin
        REQ_READY_O = 1'b0;
        case (REQ_OP_I)
            OP_ACT: REQ_READY_O = run && idle_vec[REQ_BANK_I]; // see RL11
            OP_READ, OP_WRITE: begin
                REQ_READY_O = run && open_vec[REQ_BANK_I]; // see RL12, RL4
            end
            OP_PRE: begin
                REQ_READY_O = run && (pre_ok_vec[REQ_BANK_I] ||
                    idle_vec[REQ_BANK_I]); // see RL17, RL4
            end
            OP_PRECHARGE_ALL_CMD: REQ_READY_O = run && all_closable; // see RL17
            OP_REF, OP_MODE, OP_PDOWN, OP_SREF: begin
                REQ_READY_O = run && all_idle; // see RL7, RL14, RL15
            end
            OP_STOP: REQ_READY_O = run && FULL_PAGE_I && |open_vec; // see RL13
            OP_WAKE: REQ_READY_O = (g_ff == G_PDOWN) || (g_ff == G_SREF);
            default: REQ_READY_O = 1'b0;
        endcase
    end

    assign accept = REQ_VALID_I && REQ_READY_O;

    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_bank
            logic hit;
            assign hit = accept && (REQ_BANK_I == 1'(b));
            sdram_bank_track #(
                .CW(CW)
            ) u_bank (
                .clk_i(CLOCK_I),
                .rst_n_i(RST_N_I),
                .act_i(hit && (REQ_OP_I == OP_ACT)),
                .rd_i(hit && (REQ_OP_I == OP_READ)),
                .wr_i(hit && (REQ_OP_I == OP_WRITE)),
                .auto_i(REQ_AUTO_PRE_I),
                .pre_i((hit && (REQ_OP_I == OP_PRE)) ||
                    (accept && (REQ_OP_I == OP_PRECHARGE_ALL_CMD))),
                .idle_o(idle_vec[b]),
                .open_o(open_vec[b]),
                .pre_ok_o(pre_ok_vec[b])
            );
        end
    endgenerate

    // command and address for the next edge
    always_comb begin
        nxt_cmd = CMD_NOP;
        nxt_addr = ADDR_RST;
        nxt_cke = cke_ff;
        if (accept) begin
            case (REQ_OP_I)
                OP_ACT: begin
                    nxt_cmd = CMD_ACT;
                    nxt_addr = {REQ_BANK_I, REQ_ADDR_I[ROW_W-1:0]};
                end
                OP_READ, OP_WRITE: begin
                    nxt_cmd = (REQ_OP_I == OP_READ) ? CMD_READ : CMD_WRITE;
                    nxt_addr = {REQ_BANK_I, REQ_AUTO_PRE_I, 2'h0,
                        REQ_ADDR_I[COL_W-1:0]}; // see RL18
                end
                OP_PRE: begin
                    nxt_cmd = CMD_PRE;
                    nxt_addr[BANK_BIT] = REQ_BANK_I;
                end
                OP_PRECHARGE_ALL_CMD: begin
                    nxt_cmd = CMD_PRE;
                    nxt_addr[AP_BIT] = 1'b1;
                end
                OP_REF: nxt_cmd = CMD_REF; // see RL9
                OP_MODE: begin
                    nxt_cmd = CMD_MODE;
                    nxt_addr = REQ_ADDR_I; // see RL8
                end
                OP_STOP: nxt_cmd = CMD_STOP;
                OP_PDOWN: nxt_cke = 1'b0; // see RL14
                OP_SREF: begin
                    nxt_cmd = CMD_REF; // see RL15
                    nxt_cke = 1'b0;
                end
                OP_WAKE: nxt_cke = 1'b1;
                default: nxt_cmd = CMD_NOP;
            endcase
        end
    end

    // pins registered, change on rising edge or on reset
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin // see RL1, RL2
        if (!RST_N_I) begin
            cmd_ff <= CMD_RST;
            addr_ff <= ADDR_RST;
            cke_ff <= CKE_RST;
        end else begin
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            cke_ff <= nxt_cke;
        end
    end

    // refresh, mode set and low-power sequencing
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            g_ff <= G_RUN;
            gcnt_ff <= '0;
        end else begin
            case (g_ff)
                G_RUN: begin
                    if (accept && REQ_OP_I == OP_REF) begin
                        g_ff <= G_BUSY; // see RL5
                        gcnt_ff <= CW'(RP_CYC);
                    end else if (accept && REQ_OP_I == OP_MODE) begin
                        g_ff <= G_BUSY; // see RL6
                        gcnt_ff <= CW'(MCD_CYC);
                    end else if (accept && REQ_OP_I == OP_PDOWN) begin
                        g_ff <= G_PDOWN;
                    end else if (accept && REQ_OP_I == OP_SREF) begin
                        g_ff <= G_SREF;
                    end
                end
                G_BUSY, G_WAKE: begin
                    if (gcnt_ff <= CW'(1)) begin
                        g_ff <= G_RUN;
                    end else begin
                        gcnt_ff <= gcnt_ff - CW'(1);
                    end
                end
                G_PDOWN: begin
                    if (accept) begin
                        g_ff <= G_RUN;
                    end
                end
                G_SREF: begin
                    if (accept) begin
                        g_ff <= G_WAKE;
                        gcnt_ff <= CW'(RP_CYC);
                    end
                end
                default: begin
                    g_ff <= G_RUN;
                    gcnt_ff <= '0;
                end
            endcase
        end
    end

    // assertion helpers: bank state one cycle back
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prev_idle_ff <= '1;
            prev_open_ff <= '0;
        end else begin
            prev_idle_ff <= idle_vec;
            prev_open_ff <= open_vec;
        end
    end

    assign BANK_IDLE_O = idle_vec;
    assign BANK_OPEN_O = open_vec;
    assign SD_CKE_O = cke_ff;
    assign {SD_CS_N_O, SD_RAS_N_O, SD_CAS_N_O, SD_WE_N_O} = cmd_ff;
    assign SD_ADDR_O = addr_ff;

    logic quiet_cmd;
    logic col_cmd;
    assign quiet_cmd = (cmd_ff == CMD_DESELECT) || (cmd_ff == CMD_NOP) ||
        (cmd_ff == CMD_STOP);
    assign col_cmd = (cmd_ff == CMD_READ) || (cmd_ff == CMD_WRITE);

    sequence s_busy_rp;
        (g_ff == G_BUSY) ##RP (g_ff == G_RUN);
    endsequence
    sequence s_busy_mcd;
        (g_ff == G_BUSY) ##MCD (g_ff == G_RUN);
    endsequence

    a_ref_wait_rp: assert property ( // see RL5
        (cke_ff && cmd_ff == CMD_REF) |-> s_busy_rp)
        else $error("refresh wait not equal to precharge time");
    a_mode_wait: assert property ( // see RL6
        (cmd_ff == CMD_MODE) |-> s_busy_mcd)
        else $error("mode set wait length wrong");
    a_busy_quiet: assert property ( // see RL5
        (g_ff == G_BUSY) |=> quiet_cmd)
        else $error("command issued while refresh or mode set busy");
    a_both_idle: assert property ( // see RL7
        (cmd_ff == CMD_REF || cmd_ff == CMD_MODE) |-> &prev_idle_ff)
        else $error("refresh or mode set with a bank not idle");
    a_act_idle: assert property ( // see RL11
        (cmd_ff == CMD_ACT) |-> prev_idle_ff[addr_ff[BANK_BIT]])
        else $error("activate to a bank that is not idle");
    a_col_open: assert property ( // see RL12
        col_cmd |-> prev_open_ff[addr_ff[BANK_BIT]])
        else $error("read or write to a bank not active");
    a_col_a89: assert property ( // see RL18
        col_cmd |-> (addr_ff[9:8] == 2'h0))
        else $error("column command with address bits 8 or 9 set");
    a_sref_entry: assert property ( // see RL15
        (accept && REQ_OP_I == OP_SREF) |=>
        (!cke_ff && cmd_ff == CMD_REF) ##1 (!cke_ff && cmd_ff == CMD_NOP))
        else $error("self refresh entry sequence wrong");
    a_lowpow_quiet: assert property ( // see RL14
        (!cke_ff && $past(!cke_ff)) |-> (cmd_ff == CMD_NOP))
        else $error("command driven during power down");
    a_stop_page: assert property ( // see RL13
        (cmd_ff == CMD_STOP) |-> $past(FULL_PAGE_I))
        else $error("burst stop without full page burst");

endmodule

/* File: bench/sdram_dev_model.sv */
`timescale 1ns/100ps
module sdram_dev_model
    import sdram_host_pkg::*;
(
    input wire logic clk_i,
    input wire logic cke_i,
    input wire logic [3:0] cmd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic full_page_i,
    output logic [ADDR_W-1:0] mode_o,
    output logic pdown_o,
    output logic sref_o,
    output logic [7:0] err_o
);
    logic [1:0] open_ff = 2'b00;
    logic [3:0] cnt_ff [2] = '{4'h0, 4'h0};
    logic [3:0] ras_ff [2] = '{4'h0, 4'h0};
    logic [3:0] gcnt_ff = 4'h0;
    logic cke_ff = 1'b1;
    logic full_ff = 1'b0;
    logic b;

    initial begin
        mode_o = 12'h000;
        pdown_o = 1'b0;
        sref_o = 1'b0;
        err_o = 8'h00;
    end

    function automatic logic idle(input logic k);
        return !open_ff[k] && cnt_ff[k] == 4'h0;
    endfunction

    // counters drop first so a delay of n allows a command n edges on
    always @(posedge clk_i) begin
        b = addr_i[BANK_BIT];
        for (int k = 0; k < 2; k++) begin
            if (cnt_ff[k] != 4'h0) cnt_ff[k] = cnt_ff[k] - 4'h1;
            if (ras_ff[k] != 4'h0) ras_ff[k] = ras_ff[k] - 4'h1;
        end
        if (gcnt_ff != 4'h0) gcnt_ff = gcnt_ff - 4'h1;
        if (sref_o || pdown_o) begin
            // only clock enable is looked at here
            if (cke_i && sref_o) gcnt_ff = 4'(RP_CYC);
            if (cke_i) begin
                sref_o = 1'b0;
                pdown_o = 1'b0;
            end
        end else if (!cke_i && cke_ff) begin
            if (!(idle(0) && idle(1))) err_o++;
            if (cmd_i == CMD_REF) sref_o = 1'b1;
            else pdown_o = 1'b1;
        end else begin
            if (!cmd_i[3] && cmd_i[3:1] != 3'b011 && gcnt_ff != 4'h0) begin
                err_o++;
            end
            case (cmd_i)
                CMD_ACT: begin
                    if (!idle(b)) err_o++;
                    open_ff[b] = 1'b1;
                    cnt_ff[b] = 4'(RCD_CYC);
                    ras_ff[b] = 4'(RAS_CYC);
                end
                // column bits 9:8 are never looked at
                CMD_READ, CMD_WRITE: begin
                    if (!open_ff[b] || cnt_ff[b] != 4'h0) err_o++;
                    if (addr_i[AP_BIT]) begin
                        open_ff[b] = 1'b0;
                        cnt_ff[b] = (cmd_i == CMD_WRITE) ?
                            4'(DAL_CYC) : 4'(RDAP_CYC);
                    end
                end
                CMD_PRE: for (int k = 0; k < 2; k++) begin
                    if (addr_i[AP_BIT] || k[0] == b) begin
                        if (open_ff[k] ? ras_ff[k] != 0 : cnt_ff[k] != 0) begin
                            err_o++;
                        end
                        if (open_ff[k]) cnt_ff[k] = 4'(RP_CYC);
                        open_ff[k] = 1'b0;
                    end
                end
                CMD_REF, CMD_MODE: begin
                    if (!(idle(0) && idle(1))) err_o++;
                    if (cmd_i == CMD_MODE) mode_o = addr_i;
                    gcnt_ff = 4'(cmd_i == CMD_REF ? RP_CYC : MCD_CYC);
                end
                CMD_STOP: if (!full_ff) err_o++;
                default: ;
            endcase
        end
        cke_ff = cke_i;
        full_ff = full_page_i;
    end
endmodule

/* File: bench/sdram_bank_command_state_rules_tb.sv */
`timescale 1ns/100ps
module sdram_bank_command_state_rules_tb
    import sdram_host_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    host_op_t req_op = OP_ACT;
    logic req_bank = 1'b0;
    logic [ADDR_W-1:0] req_addr = 12'h000;
    logic req_ap = 1'b0;
    logic full_page = 1'b0;
    logic req_ready;
    logic [1:0] bank_idle;
    logic [1:0] bank_open;
    logic sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
    logic [ADDR_W-1:0] sd_addr;
    logic [3:0] cmd;
    logic [ADDR_W-1:0] dev_mode;
    logic dev_pd, dev_sr;
    logic [7:0] dev_err;
    int n_fail = 0;
    int n_checks = 0;

    assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};

    always #12.5 clk = ~clk;

    sdram_host_ctrl dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(req_valid),
        .REQ_OP_I(req_op), .REQ_BANK_I(req_bank), .REQ_ADDR_I(req_addr),
        .REQ_AUTO_PRE_I(req_ap), .FULL_PAGE_I(full_page),
        .REQ_READY_O(req_ready), .BANK_IDLE_O(bank_idle),
        .BANK_OPEN_O(bank_open), .SD_CKE_O(sd_cke), .SD_CS_N_O(sd_cs_n),
        .SD_RAS_N_O(sd_ras_n), .SD_CAS_N_O(sd_cas_n), .SD_WE_N_O(sd_we_n),
        .SD_ADDR_O(sd_addr)
    );

    sdram_dev_model dev (
        .clk_i(clk), .cke_i(sd_cke), .cmd_i(cmd), .addr_i(sd_addr),
        .full_page_i(full_page), .mode_o(dev_mode), .pdown_o(dev_pd),
        .sref_o(dev_sr), .err_o(dev_err)
    );

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic put(input host_op_t op, input logic bk,
                       input logic [11:0] a, input logic ap);
        req_op = op;
        req_bank = bk;
        req_addr = a;
        req_ap = ap;
    endtask

    // held until the edge that takes it; ready is read mid-cycle
    task automatic issue(input host_op_t op, input logic bk,
                         input logic [11:0] a, input logic ap);
        int i;
        put(op, bk, a, ap);
        req_valid = 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (req_ready === 1'b1) break;
            @(posedge clk);
            #1;
        end
        if (i == 40) begin
            n_fail++;
            finish_test();
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask

    task automatic refused(input host_op_t op, input logic bk);
        put(op, bk, 12'h000, 1'b0);
        @(negedge clk);
        chk(req_ready, 1'b0);
        @(posedge clk);
        #1;
    endtask

    task automatic exp_ready(input host_op_t op, input logic bk, input int n);
        repeat (n) refused(op, bk);
        put(op, bk, 12'h000, 1'b0);
        @(negedge clk);
        chk(req_ready, 1'b1);
        @(posedge clk);
        #1;
    endtask

    task automatic s_mode_ref();
        refused(OP_WAKE, 1'b0);
        issue(OP_MODE, 1'b0, 12'hA5C, 1'b0);
        chk(cmd, CMD_MODE);
        chk(sd_addr, 12'hA5C);
        exp_ready(OP_ACT, 1'b0, MCD_CYC);
        chk(dev_mode, 12'hA5C);
        issue(OP_REF, 1'b0, 12'hFFF, 1'b0);
        chk(cmd, CMD_REF);
        chk(sd_addr, 12'h000);
        exp_ready(OP_MODE, 1'b0, RP_CYC);
    endtask

    task automatic s_act_read();
        issue(OP_ACT, 1'b0, 12'h5A5, 1'b0);
        chk(cmd, CMD_ACT);
        chk(sd_addr, 12'h5A5);
        chk(bank_idle, 2'b10);
        exp_ready(OP_READ, 1'b0, RCD_CYC);
        refused(OP_REF, 1'b0);
        refused(OP_STOP, 1'b0);
        full_page = 1'b1;
        issue(OP_STOP, 1'b0, 12'h000, 1'b0);
        chk(cmd, CMD_STOP);
        full_page = 1'b0;
        issue(OP_READ, 1'b0, 12'h3C3, 1'b1);
        chk(cmd, CMD_READ);
        chk(sd_addr, 12'h4C3);
        exp_ready(OP_ACT, 1'b0, RDAP_CYC);
    endtask

    task automatic s_write_ap();
        issue(OP_ACT, 1'b1, 12'h123, 1'b0);
        chk(sd_addr, 12'h923);
        exp_ready(OP_PRE, 1'b1, RAS_CYC);
        issue(OP_WRITE, 1'b1, 12'h0FF, 1'b1);
        chk(cmd, CMD_WRITE);
        chk(sd_addr, 12'hCFF);
        refused(OP_READ, 1'b1);
        exp_ready(OP_ACT, 1'b1, DAL_CYC - 1);
    endtask

    task automatic s_precharge_all_cmd();
        issue(OP_ACT, 1'b0, 12'h011, 1'b0);
        @(posedge clk);
        #1;
        issue(OP_ACT, 1'b1, 12'h022, 1'b0);
        chk(bank_open, 2'b01);
        exp_ready(OP_PRE, 1'b1, RAS_CYC);
        issue(OP_PRE, 1'b1, 12'h000, 1'b0);
        chk(cmd, CMD_PRE);
        chk(sd_addr[11:10], 2'b10);
        exp_ready(OP_PRECHARGE_ALL_CMD, 1'b0, RP_CYC);
        issue(OP_PRECHARGE_ALL_CMD, 1'b0, 12'h000, 1'b0);
        chk(sd_addr[10], 1'b1);
        exp_ready(OP_REF, 1'b0, RP_CYC);
    endtask

    task automatic s_power();
        issue(OP_PDOWN, 1'b0, 12'h000, 1'b0);
        chk(sd_cke, 1'b0);
        chk(cmd, CMD_NOP);
        refused(OP_ACT, 1'b0);
        chk(dev_pd, 1'b1);
        issue(OP_WAKE, 1'b0, 12'h000, 1'b0);
        chk(sd_cke, 1'b1);
        exp_ready(OP_ACT, 1'b0, 0);
        issue(OP_SREF, 1'b0, 12'h000, 1'b0);
        chk(sd_cke, 1'b0);
        chk(cmd, CMD_REF);
        refused(OP_REF, 1'b0);
        chk(dev_sr, 1'b1);
        issue(OP_WAKE, 1'b0, 12'h000, 1'b0);
        chk(sd_cke, 1'b1);
        exp_ready(OP_ACT, 1'b0, RP_CYC);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        chk(cmd, CMD_DESELECT);
        chk(sd_cke, 1'b1);
        chk(sd_addr, 12'h000);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        chk(cmd, CMD_NOP);
        s_mode_ref();
        s_act_read();
        s_write_ap();
        s_precharge_all_cmd();
        s_power();
        // any command the device saw at a wrong moment while clock enable stayed high is counted there
        chk(dev_err, 8'h00);
        finish_test();
    end
endmodule
